/* src/ucr_ctrl_req.sv */
// Control request unit: standard request decode, descriptor RAM, replies
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module ucr_ctrl_req (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [ucr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_we,
  input  wire logic                       reg_re,
  output logic      [31:0]                reg_rdata,
  input  wire logic                       setup_valid,
  input  wire logic [7:0]                 setup_type,
  input  wire logic [7:0]                 setup_request,
  input  wire logic [15:0]                setup_value,
  input  wire logic [15:0]                setup_index,
  input  wire logic [15:0]                setup_length,
  input  wire logic                       ss_mode,
  input  wire logic                       status_done,
  input  wire logic [7:0]                 ep_halt_set,
  input  wire logic                       in_ready,
  output logic                            in_valid,
  output logic      [7:0]                 in_byte,
  output logic                            in_last,
  output logic                            zlp_req,
  output logic                            stall,
  output logic                            req_done,
  output logic      [6:0]                 dev_addr,
  output logic      [7:0]                 ep_halt,
  output logic      [7:0]                 toggle_clr,
  output logic      [7:0]                 seq_clr
);
  import ucr_pkg::*;

  ucr_state_t               state_reg;
  logic [7:0]               type_reg;
  logic [7:0]               req_reg;
  logic [15:0]              value_reg;
  logic [15:0]              index_reg;
  logic [15:0]              length_reg;
  logic [15:0]              hwc_reg;
  logic [31:0]              dram [DRAM_WORDS];
  logic [DPTR_W-1:0]        dptr [DPTR_SLOTS];
  logic [31:0]              rdata_reg;
  logic                     in_valid_reg;
  logic [7:0]               in_byte_reg;
  logic                     in_last_reg;
  logic                     zlp_reg;
  logic                     zlp_need_reg;
  logic                     stall_reg;
  logic                     done_reg;
  logic [6:0]               addr_reg;
  logic [6:0]               addr_pend_reg;
  logic                     addr_upd_reg;
  logic [7:0]               halt_reg;
  logic [7:0]               toggle_reg;
  logic [7:0]               seq_reg;
  logic [9:0]               cnt_reg;
  logic [9:0]               len_reg;
  logic                     ram_sel_reg;
  logic [6:0]               start_reg;
  logic [15:0]              reply_reg;

  // Decode results
  logic [4:0]               rcp;
  logic [7:0]               idx_lo;
  logic                     idx_hi_ok;
  logic                     ep_ok;
  logic [2:0]               iep;
  logic [7:0]               dtype;
  logic [7:0]               dindex;
  logic [3:0]               slot;
  logic                     desc_ok;
  logic [9:0]               desc_len;
  logic                     ok;
  logic                     has_data;
  logic                     use_ram;
  logic [15:0]              reply;
  logic [9:0]               full_len;
  logic [9:0]               send_len;
  logic                     zlp_need;
  logic [9:0]               maxpkt;
  logic [15:0]              dev_status;
  logic [15:0]              if_status;
  logic                     decode_ok;
  logic                     clr_feat;
  logic                     start_send;
  logic                     take;
  logic [9:0]               nxt_cnt;
  logic [31:0]              word;
  logic [7:0]               nxt_byte;
  logic                     dptr_hit;
  logic                     dram_hit;

  assign reg_rdata  = rdata_reg;
  assign in_valid   = in_valid_reg;
  assign in_byte    = in_byte_reg;
  assign in_last    = in_last_reg;
  assign zlp_req    = zlp_reg;
  assign stall      = stall_reg;
  assign req_done   = done_reg;
  assign dev_addr   = addr_reg;
  assign ep_halt    = halt_reg;
  assign toggle_clr = toggle_reg;
  assign seq_clr    = seq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  always_comb begin
    rcp       = type_reg[4:0];
    idx_lo    = index_reg[7:0];
    idx_hi_ok = ss_mode || (index_reg[15:8] == 8'h00);
    ep_ok     = idx_hi_ok && (idx_lo == EPC_CTRL_OUT || idx_lo == EPC_CTRL_IN ||
                idx_lo == EPC_BULK_IN || idx_lo == EPC_BULK_OUT || idx_lo == EPC_INT_IN);
    iep       = {idx_lo[1:0], idx_lo[7]};
    maxpkt    = ss_mode ? MAXPKT_SS : MAXPKT_HS;
    dev_status = 16'h0000;
    dev_status[0] = hwc_reg[HWC_PWR];
    if (ss_mode) begin
      dev_status[2] = hwc_reg[HWC_U1];
      dev_status[3] = hwc_reg[HWC_U2];
      dev_status[4] = hwc_reg[HWC_LTM];
    end else begin
      dev_status[1] = hwc_reg[HWC_RWAKE];
    end
    if_status = 16'h0000;
    if (ss_mode) begin
      if_status[0] = hwc_reg[HWC_FRW_CAP];
      if_status[1] = hwc_reg[HWC_FRW_EN];
    end
  end

  // Descriptor selection from the request pointer
  always_comb begin
    dtype   = value_reg[15:8];
    dindex  = value_reg[7:0];
    slot    = SLOT_DEVICE;
    desc_ok = 1'b0;
    case (dtype)
      DT_DEVICE: begin
        slot    = SLOT_DEVICE;
        desc_ok = 1'b1;
      end
      DT_CONFIG: begin
        slot    = SLOT_CONFIG;
        desc_ok = 1'b1;
      end
      DT_STRING: begin
        slot    = SLOT_STR0 + dindex[3:0];
        desc_ok = (dindex < NUM_STRINGS) && (dindex != 8'h00 || index_reg == 16'h0000);
      end
      DT_QUAL: begin
        slot    = SLOT_QUAL;
        desc_ok = !ss_mode;
      end
      DT_OTHER: begin
        slot    = SLOT_OTHER;
        desc_ok = !ss_mode;
      end
      DT_BOS: begin
        slot    = SLOT_BOS;
        desc_ok = ss_mode;
      end
      default: desc_ok = 1'b0;
    endcase
    if (dtype != DT_STRING && (dindex != 8'h00 || index_reg != 16'h0000)) begin
      desc_ok = 1'b0;
    end
    desc_len = dptr[slot][DPTR_W-1:DPTR_LEN_LSB];
    if (desc_len == 10'h000) begin
      desc_ok = 1'b0;
    end
  end

  always_comb begin
    ok       = 1'b0;
    has_data = 1'b0;
    use_ram  = 1'b0;
    reply    = 16'h0000;
    full_len = 10'h000;
    case (req_reg)
      REQ_GET_STATUS: begin
        has_data = 1'b1;
        full_len = 10'h002;
        case (rcp)
          RCP_DEVICE: begin
            ok    = index_reg == 16'h0000;
            reply = dev_status;
          end
          RCP_IFACE: begin
            ok    = index_reg == 16'h0000;
            reply = if_status;
          end
          RCP_EP: begin
            ok    = ep_ok;
            reply = {15'h0000, halt_reg[iep]};
          end
          default: ok = 1'b0;
        endcase
      end
      REQ_CLEAR_FEAT: begin
        case (rcp)
          RCP_DEVICE: ok = index_reg == 16'h0000 && (ss_mode ?
                        (value_reg == FEAT_U1 || value_reg == FEAT_U2 || value_reg == FEAT_LTM) :
                        value_reg == FEAT_RWAKE);
          RCP_IFACE:  ok = ss_mode && index_reg == 16'h0000 && value_reg == FEAT_FUNC_SUS;
          RCP_EP:     ok = ep_ok && value_reg == FEAT_EP_HALT;
          default:    ok = 1'b0;
        endcase
      end
      REQ_SET_ADDRESS: begin
        ok = rcp == RCP_DEVICE && value_reg[15:7] == 9'h000 && index_reg == 16'h0000;
      end
      REQ_GET_DESC: begin
        has_data = 1'b1;
        use_ram  = 1'b1;
        full_len = desc_len;
        ok       = rcp == RCP_DEVICE && desc_ok;
      end
      REQ_GET_CONFIG: begin
        has_data = 1'b1;
        full_len = 10'h001;
        ok       = rcp == RCP_DEVICE && index_reg == 16'h0000;
        reply    = {8'h00, hwc_reg[15:HWC_CFG_LSB]};
      end
      REQ_GET_IFACE: begin
        has_data = 1'b1;
        full_len = 10'h001;
        ok       = rcp == RCP_IFACE && index_reg == 16'h0000;
      end
      default: ok = 1'b0;
    endcase
    if (type_reg[6:5] != 2'b00 || type_reg[7] != has_data) begin
      ok = 1'b0;
    end
    send_len = (length_reg < {6'h00, full_len}) ? length_reg[9:0] : full_len;
    zlp_need = has_data && (length_reg > {6'h00, full_len}) &&
               ((full_len & (maxpkt - 10'h001)) == 10'h000);
  end

  assign decode_ok  = state_reg == ST_DECODE && ok;
  assign clr_feat   = decode_ok && req_reg == REQ_CLEAR_FEAT;
  assign start_send = decode_ok && has_data && send_len != 10'h000;
  assign take       = state_reg == ST_SEND && in_valid_reg && in_ready;
  assign nxt_cnt    = start_send ? 10'h000 : cnt_reg + 10'h001;

  // Next reply byte, little-endian within each RAM word
  always_comb begin
    if (start_send) begin
      word = use_ram ? dram[dptr[slot][DPTR_LEN_LSB-1:0]] : {16'h0000, reply};
    end else begin
      word = ram_sel_reg ? dram[start_reg + nxt_cnt[8:2]] : {16'h0000, reply_reg};
    end
    case (nxt_cnt[1:0])
      2'b00:   nxt_byte = word[7:0];
      2'b01:   nxt_byte = word[15:8];
      2'b10:   nxt_byte = word[23:16];
      default: nxt_byte = word[31:24];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (setup_valid) begin
      state_reg <= ST_DECODE;
    end else begin
      case (state_reg)
        ST_IDLE:   state_reg <= ST_IDLE;
        ST_DECODE: begin
          if (!ok) begin
            state_reg <= ST_IDLE;
          end else if (start_send) begin
            state_reg <= ST_SEND;
          end else begin
            state_reg <= ST_STATUS;
          end
        end
        ST_SEND: begin
          if (take && in_last_reg) begin
            state_reg <= ST_STATUS;
          end
        end
        ST_STATUS: begin
          if (status_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      type_reg   <= 8'h00;
      req_reg    <= 8'h00;
      value_reg  <= 16'h0000;
      index_reg  <= 16'h0000;
      length_reg <= 16'h0000;
    end else if (setup_valid) begin
      type_reg   <= setup_type;
      req_reg    <= setup_request;
      value_reg  <= setup_value;
      index_reg  <= setup_index;
      length_reg <= setup_length;
    end
  end

  // Stall marks the request refused; endpoint halt bits stay as they are
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else if (setup_valid) begin
      stall_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      if (state_reg == ST_DECODE && !ok) begin
        stall_reg <= 1'b1;
      end
      if ((decode_ok && !start_send) || (take && in_last_reg)) begin
        done_reg <= 1'b1;
      end else if (state_reg == ST_STATUS && status_done) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Data stage byte stream
  always_ff @(posedge clk) begin
    if (!rst_n || setup_valid) begin
      in_valid_reg <= 1'b0;
      in_byte_reg  <= 8'h00;
      in_last_reg  <= 1'b0;
      zlp_reg      <= 1'b0;
      zlp_need_reg <= 1'b0;
      cnt_reg      <= 10'h000;
      len_reg      <= 10'h000;
      ram_sel_reg  <= 1'b0;
      start_reg    <= 7'h00;
      reply_reg    <= 16'h0000;
    end else begin
      zlp_reg <= 1'b0;
      if (start_send) begin
        in_valid_reg <= 1'b1;
        in_byte_reg  <= nxt_byte;
        in_last_reg  <= send_len == 10'h001;
        zlp_need_reg <= zlp_need;
        cnt_reg      <= 10'h000;
        len_reg      <= send_len;
        ram_sel_reg  <= use_ram;
        start_reg    <= dptr[slot][DPTR_LEN_LSB-1:0];
        reply_reg    <= reply;
      end else if (take) begin
        if (in_last_reg) begin
          in_valid_reg <= 1'b0;
          in_last_reg  <= 1'b0;
          zlp_reg      <= zlp_need_reg;
        end else begin
          cnt_reg     <= nxt_cnt;
          in_byte_reg <= nxt_byte;
          in_last_reg <= nxt_cnt + 10'h001 == len_reg;
        end
      end
    end
  end

  // Address switches only once the status stage has completed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_reg      <= 7'h00;
      addr_pend_reg <= 7'h00;
      addr_upd_reg  <= 1'b0;
    end else begin
      if (setup_valid) begin
        addr_upd_reg <= 1'b0;
      end else if (decode_ok && req_reg == REQ_SET_ADDRESS) begin
        addr_pend_reg <= value_reg[6:0];
        addr_upd_reg  <= 1'b1;
      end else if (state_reg == ST_STATUS && status_done && addr_upd_reg) begin
        addr_reg     <= addr_pend_reg;
        addr_upd_reg <= 1'b0;
      end
    end
  end

  // Halt bits: a set from the core wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_reg   <= 8'h00;
      toggle_reg <= 8'h00;
      seq_reg    <= 8'h00;
    end else begin
      toggle_reg <= 8'h00;
      seq_reg    <= 8'h00;
      if (clr_feat && rcp == RCP_EP) begin
        halt_reg <= ((halt_reg & ~(8'h01 << iep)) | ep_halt_set) & IEP_USED;
        if (ss_mode) begin
          seq_reg <= 8'h01 << iep;
        end else begin
          toggle_reg <= 8'h01 << iep;
        end
      end else begin
        halt_reg <= (halt_reg | ep_halt_set) & IEP_USED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign dptr_hit = reg_addr[9:6] == REG_DPTR_BASE[9:6];
  assign dram_hit = reg_addr[9] == REG_DRAM_BASE[9];

  // Software write wins over a feature clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hwc_reg <= HWC_RESET;
    end else if (reg_we && reg_addr == REG_HW_CONFIG) begin
      hwc_reg <= reg_wdata[15:0];
    end else if (clr_feat) begin
      if (rcp == RCP_DEVICE) begin
        case (value_reg)
          FEAT_RWAKE: hwc_reg[HWC_RWAKE] <= 1'b0;
          FEAT_U1:    hwc_reg[HWC_U1]    <= 1'b0;
          FEAT_U2:    hwc_reg[HWC_U2]    <= 1'b0;
          FEAT_LTM:   hwc_reg[HWC_LTM]   <= 1'b0;
          default:    hwc_reg            <= hwc_reg;
        endcase
      end else if (rcp == RCP_IFACE) begin
        hwc_reg[HWC_FRW_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DPTR_SLOTS; i++) begin
        dptr[i] <= '0;
      end
    end else if (reg_we && dptr_hit) begin
      dptr[reg_addr[5:2]] <= reg_wdata[DPTR_W-1:0];
    end
  end

  // Descriptor RAM, filled by the loader or driver after reset
  always_ff @(posedge clk) begin
    if (reg_we && dram_hit) begin
      dram[reg_addr[8:2]] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_re) begin
      if (reg_addr == REG_HW_CONFIG) begin
        rdata_reg <= {16'h0000, hwc_reg};
      end else if (reg_addr == REG_STATUS) begin
        rdata_reg <= {8'h00, halt_reg, 4'h0, stall_reg, 1'b0, state_reg, 1'b0, addr_reg};
      end else if (dptr_hit) begin
        rdata_reg <= {15'h0000, dptr[reg_addr[5:2]]};
      end else if (dram_hit) begin
        rdata_reg <= dram[reg_addr[8:2]];
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

endmodule

/* src/ucr_pkg.sv */
// Constants and types of the USB control request unit
package ucr_pkg;

  // Register port
  localparam int              ADDR_W        = 10;
  localparam logic [9:0]      REG_HW_CONFIG = 10'h000;
  localparam logic [9:0]      REG_STATUS    = 10'h004;
  localparam logic [9:0]      REG_DPTR_BASE = 10'h040;
  localparam logic [9:0]      REG_DRAM_BASE = 10'h200;
  localparam int              DRAM_WORDS    = 128;
  localparam int              DPTR_SLOTS    = 16;

  // Hardware config register fields
  localparam int              HWC_PWR       = 0;
  localparam int              HWC_RWAKE     = 1;
  localparam int              HWC_U1        = 2;
  localparam int              HWC_U2        = 3;
  localparam int              HWC_LTM       = 4;
  localparam int              HWC_FRW_EN    = 5;
  localparam int              HWC_FRW_CAP   = 6;
  localparam int              HWC_CFG_LSB   = 8;
  localparam logic [15:0]     HWC_RESET     = 16'h0000;

  // Descriptor pointer word: {length[9:0], start word[6:0]}
  localparam int              DPTR_W        = 17;
  localparam int              DPTR_LEN_LSB  = 7;

  // Standard requests
  localparam logic [7:0]      REQ_GET_STATUS  = 8'h00;
  localparam logic [7:0]      REQ_CLEAR_FEAT  = 8'h01;
  localparam logic [7:0]      REQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0]      REQ_GET_DESC    = 8'h06;
  localparam logic [7:0]      REQ_GET_CONFIG  = 8'h08;
  localparam logic [7:0]      REQ_GET_IFACE   = 8'h0a;

  // Recipients
  localparam logic [4:0]      RCP_DEVICE    = 5'h00;
  localparam logic [4:0]      RCP_IFACE     = 5'h01;
  localparam logic [4:0]      RCP_EP        = 5'h02;

  // Feature selectors
  localparam logic [15:0]     FEAT_EP_HALT  = 16'h0000;
  localparam logic [15:0]     FEAT_FUNC_SUS = 16'h0000;
  localparam logic [15:0]     FEAT_RWAKE    = 16'h0001;
  localparam logic [15:0]     FEAT_U1       = 16'h0030;
  localparam logic [15:0]     FEAT_U2       = 16'h0031;
  localparam logic [15:0]     FEAT_LTM      = 16'h0032;

  // Descriptor types and pointer slots
  localparam logic [7:0]      DT_DEVICE     = 8'h01;
  localparam logic [7:0]      DT_CONFIG     = 8'h02;
  localparam logic [7:0]      DT_STRING     = 8'h03;
  localparam logic [7:0]      DT_QUAL       = 8'h06;
  localparam logic [7:0]      DT_OTHER      = 8'h07;
  localparam logic [7:0]      DT_BOS        = 8'h0f;
  localparam logic [7:0]      NUM_STRINGS   = 8'h06;
  localparam logic [3:0]      SLOT_DEVICE   = 4'h0;
  localparam logic [3:0]      SLOT_CONFIG   = 4'h1;
  localparam logic [3:0]      SLOT_QUAL     = 4'h2;
  localparam logic [3:0]      SLOT_OTHER    = 4'h3;
  localparam logic [3:0]      SLOT_BOS      = 4'h4;
  localparam logic [3:0]      SLOT_STR0     = 4'h5;

  // Endpoint codes and internal endpoints in use
  localparam logic [7:0]      EPC_CTRL_OUT  = 8'h00;
  localparam logic [7:0]      EPC_CTRL_IN   = 8'h80;
  localparam logic [7:0]      EPC_BULK_IN   = 8'h81;
  localparam logic [7:0]      EPC_BULK_OUT  = 8'h02;
  localparam logic [7:0]      EPC_INT_IN    = 8'h83;
  localparam logic [7:0]      IEP_USED      = 8'h9b;

  // Control pipe max payload
  localparam logic [9:0]      MAXPKT_HS     = 10'h040;
  localparam logic [9:0]      MAXPKT_SS     = 10'h200;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DECODE = 2'b01,
    ST_SEND   = 2'b11,
    ST_STATUS = 2'b10
  } ucr_state_t;

endpackage

/* test/ucr_ctrl_req_assertions.sv */
// Port checker of the control request unit
`timescale 1ns/1ps
module ucr_ctrl_req_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic        setup_valid,
  input wire logic        ss_mode,
  input wire logic        status_done,
  input wire logic [7:0]  ep_halt_set,
  input wire logic        in_ready,
  input wire logic        in_valid,
  input wire logic [7:0]  in_byte,
  input wire logic        in_last,
  input wire logic        zlp_req,
  input wire logic        stall,
  input wire logic        req_done,
  input wire logic [6:0]  dev_addr,
  input wire logic [7:0]  ep_halt,
  input wire logic [7:0]  toggle_clr,
  input wire logic [7:0]  seq_clr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  AST_STALL_HOLD: assert property (stall && !setup_valid |=> stall) else $error("stall dropped");
  AST_HALT_KEEP: assert property ($rose(stall) && $past(ep_halt_set) == 8'h00 |-> $stable(ep_halt))
    else $error("halt changed by stall");
  AST_ANSWER: assert property (setup_valid ##1 !setup_valid |=> stall || req_done || in_valid)
    else $error("no answer two cycles after setup");
  AST_ADDR_HOLD: assert property (!status_done |=> $stable(dev_addr)) else $error("address moved early");
  AST_DONE_CLR: assert property (req_done && status_done && !setup_valid |=> !req_done) else $error("done stuck");
  AST_TOGGLE_HS: assert property (toggle_clr != 8'h00 |-> !ss_mode) else $error("toggle clear in SS");
  AST_SEQ_SS: assert property (seq_clr != 8'h00 |-> ss_mode) else $error("sequence clear in HS");
  AST_CLR_HALT: assert property ((toggle_clr | seq_clr) != 8'h00 && $past(ep_halt_set) == 8'h00
    |-> ((toggle_clr | seq_clr) & ep_halt) == 8'h00) else $error("halt kept on clear");
  AST_UNUSED_EP: assert property ((ep_halt & 8'h64) == 8'h00) else $error("unused endpoint halted");
  AST_IN_HOLD: assert property (in_valid && !in_ready && !setup_valid |=> in_valid && $stable(in_byte))
    else $error("byte not held");
  AST_LAST_END: assert property (in_valid && in_last && in_ready && !setup_valid |=> !in_valid)
    else $error("data after last byte");
  AST_RDATA_IDLE: assert property (!reg_re |=> reg_rdata == 32'h0) else $error("read data not zero");
  AST_ZLP_PULSE: assert property (zlp_req |=> !zlp_req) else $error("zlp not a pulse");
  cover property (setup_valid ##2 stall);
  cover property (req_done && status_done);
  cover property (zlp_req);
endmodule

/* test/ucr_host_model.sv */
// Host-side model: takes data bytes and closes status stages
`timescale 1ns/1ps
module ucr_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic req_done,
  output logic      in_ready,
  output logic      status_done
);
  logic [1:0] wait_reg;
  logic       ph_reg;
  ////////////////////////////////////////////////////////////
  // Slow mode takes a byte every other cycle
  always_ff @(posedge clk) begin
    ph_reg <= rst_n ? ~ph_reg : 1'b0;
  end
  assign in_ready = slow ? ph_reg : 1'b1;
  // Status stage closed only after the action is complete
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_reg    <= 2'h0;
      status_done <= 1'b0;
    end else begin
      wait_reg    <= req_done ? wait_reg + 2'h1 : 2'h0;
      status_done <= req_done && wait_reg == 2'h2;
    end
  end
endmodule

/* test/tb.sv */
// Testbench of the control request unit
`timescale 1ns/1ps
module tb;
  import ucr_pkg::*;
  typedef struct {logic [7:0] t, r; logic [15:0] v, i, l; logic ss, st; logic [7:0] n, b; logic z;} ucr_row_t;
  logic        clk, rst_n, reg_we, reg_re, setup_valid, ss_mode, status_done, in_ready, slow;
  logic        in_valid, in_last, zlp_req, stall, req_done;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0]  setup_type, setup_request, in_byte, ep_halt_set, ep_halt, toggle_clr, seq_clr, b0, tg, sq;
  logic [15:0] setup_value, setup_index, setup_length;
  logic [6:0]  dev_addr, am;
  int          failures, n_checks, nb, nz, cyc;
  ucr_row_t    rows [16];
  ucr_ctrl_req dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .setup_valid,
    .setup_type, .setup_request, .setup_value, .setup_index, .setup_length, .ss_mode, .status_done,
    .ep_halt_set, .in_ready, .in_valid, .in_byte, .in_last, .zlp_req, .stall, .req_done, .dev_addr,
    .ep_halt, .toggle_clr, .seq_clr);
  ucr_host_model host (.clk, .rst_n, .slow, .req_done, .in_ready, .status_done);
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (in_valid === 1'b1 && in_ready === 1'b1) begin
      if (nb == 0) b0 = in_byte;
      nb++;
    end
    if (zlp_req === 1'b1) nz++;
    tg = tg | toggle_clr;
    sq = sq | seq_clr;
    if (cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a; reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic run(input ucr_row_t w);
    int k;
    @(posedge clk);
    setup_type <= w.t; setup_request <= w.r; setup_value <= w.v; setup_index <= w.i;
    setup_length <= w.l; ss_mode <= w.ss; setup_valid <= 1'b1;
    nb = 0; nz = 0; tg = 8'h00; sq = 8'h00;
    @(posedge clk);
    setup_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    for (k = 0; k < 300 && stall !== 1'b1 && req_done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    am = dev_addr;
    for (k = 0; k < 20 && req_done === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 0; reg_we = 0; reg_re = 0; reg_addr = 0; reg_wdata = 0; setup_valid = 0; setup_type = 0;
    setup_request = 0; setup_value = 0; setup_index = 0; setup_length = 0; ss_mode = 0; ep_halt_set = 0;
    slow = 0; failures = 0; n_checks = 0; nb = 0; nz = 0; cyc = 0; tg = 0; sq = 0;
    rows = '{'{8'h80, 8'h06, 16'h0100, 16'h0, 16'd64, 0, 0, 18, 8'h12, 0}, '{8'h80, 8'h06, 16'h0100, 16'h0, 16'd8, 0, 0, 8,
      8'h12, 0}, '{8'h80, 8'h06, 16'h0101, 16'h0, 16'd8, 0, 1, 0, 0, 0}, '{8'h80, 8'h06, 16'h0400, 16'h0, 16'd8, 0, 1, 0, 0, 0},
      '{8'h80, 8'h06, 16'h0f00, 16'h0, 16'd8, 0, 1, 0, 0, 0}, '{8'h80, 8'h06, 16'h0100, 16'h0409, 16'd8, 0, 1, 0, 0, 0},
      '{8'h80, 8'h06, 16'h0200, 16'h0, 16'd100, 0, 0, 64, 8'h09, 1}, '{8'h80, 8'h00, 16'h0, 16'h0, 16'd2, 0, 0, 2, 8'h03, 0},
      '{8'h80, 8'h00, 16'h0, 16'h0, 16'd2, 1, 0, 2, 8'h11, 0}, '{8'h00, 8'h01, 16'h1, 16'h0, 16'd0, 0, 0, 0, 0, 0},
      '{8'h80, 8'h00, 16'h0, 16'h0, 16'd2, 0, 0, 2, 8'h01, 0}, '{8'h81, 8'h0a, 16'h0, 16'h0, 16'd1, 0, 0, 1, 8'h00, 0},
      '{8'h81, 8'h0a, 16'h0, 16'h1, 16'd1, 0, 1, 0, 0, 0}, '{8'h82, 8'h00, 16'h0, 16'hff81, 16'd2, 1, 0, 2, 8'h00, 0},
      '{8'h80, 8'h08, 16'h0, 16'h0, 16'd1, 0, 0, 1, 8'h00, 0},
      '{8'h80, 8'h06, 16'h0300, 16'h0, 16'd8, 0, 0, 4, 8'h12, 0}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(dev_addr, 7'h00);
    wr(REG_HW_CONFIG, 32'h13);
    for (int w = 0; w < 32; w++) wr(REG_DRAM_BASE + 10'(4 * w), 32'h5a5a_0000 + 32'(w));
    wr(REG_DRAM_BASE, 32'h02000112);
    wr(REG_DRAM_BASE + 10'h020, 32'h00400209);
    wr(REG_DPTR_BASE, 32'h900);
    wr(REG_DPTR_BASE + 10'h004, 32'h2008);
    wr(REG_DPTR_BASE + 10'h014, 32'h200);
    rd(REG_HW_CONFIG, 32'h13);
    rd(10'h008, 32'h0);
    rd(REG_DPTR_BASE, 32'h900);
    foreach (rows[k]) begin
      slow <= k[0];
      run(rows[k]);
      chk(stall, rows[k].st);
      chk(nb, rows[k].n);
      if (rows[k].n != 0) chk(b0, rows[k].b);
      chk(nz, rows[k].z);
    end
    run('{8'h00, 8'h05, 16'h002a, 16'h0, 16'h0, 0, 0, 0, 0, 0});
    chk(am, 7'h00);
    chk(dev_addr, 7'h2a);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) ep_halt_set <= 8'h0c;
      @(posedge clk) ep_halt_set <= 8'h00;
      #1 chk(ep_halt, 8'h08);
      run('{8'h02, 8'h01, 16'h0, 16'h0081, 16'h0, s[0], 0, 0, 0, 0});
      chk(ep_halt, 8'h00);
      chk(tg, s ? 8'h00 : 8'h08);
      chk(sq, s ? 8'h08 : 8'h00);
    end
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(dev_addr, 7'h00);
    rd(REG_HW_CONFIG, 32'h0);
    wrap_up;
  end
endmodule
bind ucr_ctrl_req ucr_ctrl_req_chk u_chk (.clk, .rst_n, .reg_re, .reg_rdata, .setup_valid, .ss_mode,
  .status_done, .ep_halt_set, .in_ready, .in_valid, .in_byte, .in_last, .zlp_req, .stall, .req_done,
  .dev_addr, .ep_halt, .toggle_clr, .seq_clr);
